// File: logic/count_clock_select.sv
// Count pulse source for the timer counter: system clock ratios, the
// internal high clock, the time-base tick or an external pin edge.
// Assumes the internal high clock equals clk and tbc_tick is a
// one-cycle pulse on clk.
`timescale 1ns/1ps

module count_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire timer_pkg::clk_sel_t sel,
  input wire logic tbc_tick,
  input wire logic ext_rise,
  input wire logic ext_fall,
  output logic tick
);
  import timer_pkg::*;

  logic [5:0] divider;
  logic [5:0] next_divider;

  // --------------------------------------------------------------
  // Free-running divider
  // --------------------------------------------------------------

  // A tap fires when all bits below and at it are set.
  function automatic logic tap_full(input logic [5:0] d, input int tap);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i <= tap; i++) begin
      ok = ok & d[i];
    end
    return ok;
  endfunction

  always_comb begin
    next_divider = divider + 6'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divider <= prescale_reset;
    end else begin
      divider <= next_divider;
    end
  end

  // The reserved code yields no pulses so the counter holds.
  always_comb begin
    case (sel)
      clk_sys_div4: tick = tap_full(divider, div4_tap);
      clk_sys: tick = 1'b1;
      clk_high_div16: tick = tap_full(divider, div16_tap);
      clk_high_div64: tick = tap_full(divider, div64_tap);
      clk_time_base: tick = tbc_tick;
      clk_reserved: tick = 1'b0;
      clk_ext_rise: tick = ext_rise;
      clk_ext_fall: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

endmodule

// File: logic/pin_edge_sync.sv
// Two-flop synchroniser and edge detector for one external timer pin.
// Assumes the pin is asynchronous to clk and stays at a level for at
// least two clock periods between edges.
`timescale 1ns/1ps

module pin_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  // --------------------------------------------------------------
  // Synchroniser
  // --------------------------------------------------------------

  // The first flop feeds only the second; edges come from later flops.
  always_comb begin
    next_meta = pin;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  // One pulse per settled edge.
  assign rise = stable & ~last;
  assign fall = ~stable & last;

endmodule

// File: logic/timer_core.sv
// Timer module core: counter, comparators A, B and P, capture inputs,
// output pin actions, PWM, single pulse and the byte-buffered APB
// register file with sticky interrupt flags.
// Assumes an APB master on clk and asynchronous external timer pins.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module timer_core #(
  parameter logic is_standard = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tbc_tick,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  input wire logic enhanced_capture_input_b,
  output logic timer_out,
  output logic timer_out_en,
  output logic irq
);
  import timer_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------

  logic [7:0] timer_control_zero;
  logic [7:0] enhanced_control_one;
  logic [7:0] enhanced_control_two;
  logic [15:0] count;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [7:0] byte_buffer;
  logic [2:0] status;
  logic [2:0] mask;
  logic out_level;
  logic on_last;
  logic [7:0] next_control_zero;
  logic [7:0] next_control_one;
  logic [7:0] next_control_two;
  logic [15:0] next_count;
  logic [15:0] next_compare_a;
  logic [15:0] next_compare_b;
  logic [7:0] next_buffer;
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic next_out_level;
  logic next_on_last;
  logic [31:0] next_prdata;

  logic ck_rise;
  logic ck_fall;
  logic cap_a_rise;
  logic cap_a_fall;
  logic cap_b_rise;
  logic cap_b_fall;
  logic tick;
  logic run;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [15:0] width_mask;
  logic [15:0] p_target;
  logic match_a;
  logic match_b;
  logic match_p;
  logic cap_a;
  logic cap_b;
  logic trigger;
  logic [2:0] events;
  mode_t mode;

  // --------------------------------------------------------------
  // Pins and count clock
  // --------------------------------------------------------------

  // Every pin is synchronised before its edges are used.
  pin_edge_sync clock_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(external_clock_pin),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  pin_edge_sync cap_a_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(capture_input_pin),
    .rise(cap_a_rise),
    .fall(cap_a_fall)
  );

  pin_edge_sync cap_b_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(enhanced_capture_input_b),
    .rise(cap_b_rise),
    .fall(cap_b_fall)
  );

  count_clock_select clock_pick (
    .clk(clk),
    .rst_n(rst_n),
    .sel(clk_sel_t'(timer_control_zero[clk_sel_lsb +: 3])),
    .tbc_tick(tbc_tick),
    .ext_rise(ck_rise),
    .ext_fall(ck_fall),
    .tick(tick)
  );

  // --------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------

  // True when the pin edges match the selected active transition.
  function automatic logic edge_hit(input logic [1:0] io, input logic r,
                                    input logic f);
    case (io)
      io_rise: return r;
      io_fall: return f;
      io_both: return r | f;
      default: return 1'b0;
    endcase
  endfunction

  // Output level after a compare match action.
  function automatic logic pin_action(input logic [1:0] act, input logic lvl);
    case (act)
      act_low: return 1'b0;
      act_high: return 1'b1;
      act_toggle: return ~lvl;
      default: return lvl;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Comparators and events
  // --------------------------------------------------------------

  // Counter width and period comparator depend on the variant.
  assign width_mask = is_standard ? mask_sixteen : mask_ten;
  assign mode = mode_t'(enhanced_control_one[mode_lsb +: 2]);
  assign run = timer_control_zero[on_bit] & ~timer_control_zero[pause_bit];

  // Period value zero lets the counter reach its maximum.
  always_comb begin
    if (timer_control_zero[ccrp_lsb +: 3] == 3'h0) begin
      p_target = width_mask;
    end else if (is_standard) begin
      p_target = {timer_control_zero[ccrp_lsb +: 3], 13'h0000};
    end else begin
      p_target = {6'h00, timer_control_zero[ccrp_lsb +: 3], 7'h00};
    end
  end

  // A match is taken on the count pulse that finds the values equal.
  assign match_a = run & tick & (count == compare_value_a);
  assign match_p = run & tick & (count == p_target);
  assign match_b = run & tick & (count == compare_value_b) & ~is_standard;
  assign cap_a = (mode == mode_capture) & timer_control_zero[on_bit]
    & edge_hit(enhanced_control_one[io_a_lsb +: 2], cap_a_rise, cap_a_fall);
  assign cap_b = (mode == mode_capture) & timer_control_zero[on_bit] & ~is_standard
    & edge_hit(enhanced_control_two[io_b_lsb +: 2], cap_b_rise, cap_b_fall);
  assign trigger = enhanced_control_two[single_pulse_bit] & (mode == mode_compare)
    & edge_hit(enhanced_control_one[io_a_lsb +: 2], ck_rise, ck_fall);

  // Event sources of the three flags.
  always_comb begin
    events = 3'h0;
    events[flag_a_bit] = match_a | cap_a;
    events[flag_p_bit] = match_p;
    events[flag_b_bit] = match_b | cap_b;
  end

  // --------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------

  always_comb begin
    case (paddr)
      ctrl_zero_addr, ctrl_one_addr, ctrl_two_addr, count_low_addr,
      count_high_addr, cmp_a_low_addr, cmp_a_high_addr, cmp_b_low_addr,
      cmp_b_high_addr, status_addr, mask_addr: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_done = psel & penable & pwrite & mapped;
  assign rd_done = psel & ~penable & ~pwrite & mapped;

  // Read data is prepared in the setup phase; low bytes come from the buffer.
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ctrl_zero_addr: next_prdata = {24'h000000, timer_control_zero};
        ctrl_one_addr: next_prdata = {24'h000000, enhanced_control_one};
        ctrl_two_addr: next_prdata = {24'h000000, enhanced_control_two};
        count_low_addr, cmp_a_low_addr,
        cmp_b_low_addr: next_prdata = {24'h000000, byte_buffer};
        count_high_addr: next_prdata = {24'h000000, count[15:8]};
        cmp_a_high_addr: next_prdata = {24'h000000, compare_value_a[15:8]};
        cmp_b_high_addr: next_prdata = {24'h000000, compare_value_b[15:8]};
        status_addr: next_prdata = {29'h00000000, status};
        mask_addr: next_prdata = {29'h00000000, mask};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Registers, counter and output pin
  // --------------------------------------------------------------

  always_comb begin
    next_control_zero = timer_control_zero;
    next_control_one = enhanced_control_one;
    next_control_two = enhanced_control_two;
    next_compare_a = compare_value_a;
    next_compare_b = compare_value_b;
    next_buffer = byte_buffer;
    next_mask = mask;
    next_count = count;
    next_out_level = out_level;
    next_on_last = timer_control_zero[on_bit];
    // Byte-buffered writes: low goes to the buffer, high commits both.
    if (wr_done) begin
      case (paddr)
        ctrl_zero_addr: next_control_zero = pwdata[7:0];
        ctrl_one_addr: next_control_one = pwdata[7:0];
        ctrl_two_addr: next_control_two = pwdata[7:0];
        cmp_a_low_addr, cmp_b_low_addr: next_buffer = pwdata[7:0];
        cmp_a_high_addr: next_compare_a = {pwdata[7:0], byte_buffer} & width_mask;
        cmp_b_high_addr: next_compare_b = {pwdata[7:0], byte_buffer} & width_mask;
        mask_addr: next_mask = pwdata[2:0];
        default: next_mask = mask;
      endcase
    end
    // A high-byte read setup latches the low byte with the high byte.
    if (rd_done) begin
      case (paddr)
        count_high_addr: next_buffer = count[7:0];
        cmp_a_high_addr: next_buffer = compare_value_a[7:0];
        cmp_b_high_addr: next_buffer = compare_value_b[7:0];
        default: next_buffer = next_buffer;
      endcase
    end
    // Captured counts go to the compare registers.
    if (cap_a) begin
      next_compare_a = count;
    end
    if (cap_b) begin
      next_compare_b = count;
    end
    // Counting, clearing on the selected comparator, wrapping at full width.
    if (timer_control_zero[on_bit] && !on_last) begin
      next_count = count_reset;
      next_out_level = enhanced_control_one[init_level_bit];
    end else if (trigger) begin
      next_count = count_reset;
      next_out_level = ~enhanced_control_one[init_level_bit];
      next_control_zero[on_bit] = 1'b1;
      next_on_last = 1'b1; // A hardware start is not a software on edge.
    end else if (run && tick) begin
      if ((enhanced_control_one[cclr_bit] && match_a) ||
          (!enhanced_control_one[cclr_bit] && match_p)) begin
        next_count = count_reset;
      end else begin
        next_count = (count + 16'h0001) & width_mask;
      end
      if (mode == mode_compare && match_a) begin
        next_out_level = pin_action(enhanced_control_one[io_a_lsb +: 2], out_level);
        if (enhanced_control_two[single_pulse_bit]) begin
          next_out_level = enhanced_control_one[init_level_bit];
          next_control_zero[on_bit] = 1'b0;
        end
      end
    end
    // Hardware set wins over a software clear in the same cycle.
    next_status = status | events;
    if (wr_done && paddr == status_addr) begin
      next_status = (status & ~pwdata[2:0]) | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_zero <= ctrl_reset;
      enhanced_control_one <= ctrl_reset;
      enhanced_control_two <= ctrl_reset;
      compare_value_a <= count_reset;
      compare_value_b <= count_reset;
      count <= count_reset;
      byte_buffer <= ctrl_reset;
      status <= flags_reset;
      mask <= flags_reset;
      out_level <= 1'b0;
      on_last <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      timer_control_zero <= next_control_zero;
      enhanced_control_one <= next_control_one;
      enhanced_control_two <= next_control_two;
      compare_value_a <= next_compare_a;
      compare_value_b <= next_compare_b;
      count <= next_count;
      byte_buffer <= next_buffer;
      status <= next_status;
      mask <= next_mask;
      out_level <= next_out_level;
      on_last <= next_on_last;
      prdata <= next_prdata;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------

  // PWM shares the compare output pin; active while below duty value.
  always_comb begin
    if (mode == mode_pwm) begin
      timer_out = ((count < compare_value_a) & timer_control_zero[on_bit])
        ^ enhanced_control_one[polarity_bit];
    end else begin
      timer_out = out_level ^ enhanced_control_one[polarity_bit];
    end
  end

  // The pin is driven only once software selects the timer function.
  assign timer_out_en = enhanced_control_two[pin_enable_bit];
  assign irq = |(status & mask);

endmodule

// File: logic/timer_pkg.sv
// Shared constants for the timer module: register map, field positions,
// reset values and encodings of clock, mode and edge selections.
// Assumes a 32-bit APB register bus with byte addresses.
package timer_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ctrl_zero_addr = 8'h00;
  localparam logic [7:0] ctrl_one_addr = 8'h04;
  localparam logic [7:0] ctrl_two_addr = 8'h08;
  localparam logic [7:0] count_low_addr = 8'h0C;
  localparam logic [7:0] count_high_addr = 8'h10;
  localparam logic [7:0] cmp_a_low_addr = 8'h14;
  localparam logic [7:0] cmp_a_high_addr = 8'h18;
  localparam logic [7:0] cmp_b_low_addr = 8'h1C;
  localparam logic [7:0] cmp_b_high_addr = 8'h20;
  localparam logic [7:0] status_addr = 8'h24;
  localparam logic [7:0] mask_addr = 8'h28;

  // Control zero fields.
  localparam int pause_bit = 7;
  localparam int clk_sel_lsb = 4;
  localparam int on_bit = 3;
  localparam int ccrp_lsb = 0;

  // Control one fields.
  localparam int mode_lsb = 6;
  localparam int io_a_lsb = 4;
  localparam int init_level_bit = 3;
  localparam int polarity_bit = 2;
  localparam int cclr_bit = 0;

  // Control two fields.
  localparam int io_b_lsb = 4;
  localparam int single_pulse_bit = 1;
  localparam int pin_enable_bit = 0;

  // Status and mask bit positions.
  localparam int flag_a_bit = 0;
  localparam int flag_p_bit = 1;
  localparam int flag_b_bit = 2;

  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [2:0] flags_reset = 3'h0;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [5:0] prescale_reset = 6'h00;

  // Counter widths of the variants.
  localparam logic [15:0] mask_ten = 16'h03FF;
  localparam logic [15:0] mask_sixteen = 16'hFFFF;
  localparam int shift_ten = 7;
  localparam int shift_sixteen = 13;

  // Clock select codes.
  typedef enum logic [2:0] {
    clk_sys_div4 = 3'h0,
    clk_sys = 3'h1,
    clk_high_div16 = 3'h2,
    clk_high_div64 = 3'h3,
    clk_time_base = 3'h4,
    clk_reserved = 3'h5,
    clk_ext_rise = 3'h6,
    clk_ext_fall = 3'h7
  } clk_sel_t;

  // Operating modes.
  typedef enum logic [1:0] {
    mode_compare = 2'h0,
    mode_capture = 2'h1,
    mode_pwm = 2'h2,
    mode_timer = 2'h3
  } mode_t;

  // Edge and pin action codes of the two-bit io fields.
  localparam logic [1:0] io_rise = 2'h0;
  localparam logic [1:0] io_fall = 2'h1;
  localparam logic [1:0] io_both = 2'h2;
  localparam logic [1:0] act_none = 2'h0;
  localparam logic [1:0] act_low = 2'h1;
  localparam logic [1:0] act_high = 2'h2;
  localparam logic [1:0] act_toggle = 2'h3;

  // Prescaler tap positions.
  localparam int div4_tap = 1;
  localparam int div16_tap = 3;
  localparam int div64_tap = 5;

endpackage

// File: verification/timer_core_checker.sv
// Port checker for timer_core: APB answers, read data, widths, pin enable, irq.
// Assumes it is bound into every timer_core instance.
`timescale 1ns/1ps

module timer_core_checker #(
  parameter logic is_standard = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_out_en,
  input wire logic irq
);
  import timer_pkg::*;
  logic acc;
  logic bad;
  logic ctl2_wr;
  logic hi_rd;

  // Access phase, unmapped offset, pin enable write and high byte read.
  assign acc = psel && penable;
  assign bad = (paddr > mask_addr) || (paddr[1:0] != 2'h0);
  assign ctl2_wr = acc && pwrite && paddr == ctrl_two_addr;
  assign hi_rd = acc && !pwrite && (paddr == count_high_addr ||
                 paddr == cmp_a_high_addr || paddr == cmp_b_high_addr);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A mask write of zero, which must silence the interrupt.
  sequence s_mask_zero;
    acc && pwrite && paddr == mask_addr && pwdata[2:0] == 3'h0;
  endsequence

  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_high_width: assert property (hi_rd |-> (is_standard ? prdata[31:8] == 24'h0 :
    prdata[31:2] == 30'h0)) else $error("high byte wider than counter");
  a_pin_en_write: assert property (ctl2_wr |=> timer_out_en == $past(pwdata[0]))
    else $error("pin enable not taken from write");
  a_pin_en_hold: assert property ($changed(timer_out_en) |-> $past(ctl2_wr))
    else $error("pin enable moved without write");
  a_irq_masked: assert property (s_mask_zero |=> !irq [*2])
    else $error("irq high with all masked");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read");
endmodule

bind timer_core timer_core_checker #(.is_standard(is_standard)) timer_core_checker_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_out_en(timer_out_en), .irq(irq)
);

// File: verification/timer_core_tb_top.sv
// Self-checking bench for timer_core: APB tasks and directed tests.
// Assumes the 10-bit variant and the pin model on the far side.
`timescale 1ns/1ps

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end

module timer_core_tb_top;
  import timer_pkg::*;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tbc_tick;
  logic ext_clk;
  logic cap_a;
  logic cap_b;
  logic timer_out;
  logic timer_out_en;
  logic irq;
  logic err;
  logic [31:0] q;
  logic [15:0] cnt;
  int errors;
  int total_checks;
  logic [15:0] lo_tab [6] = '{16'h003E, 16'h00FA, 16'h000F, 16'h0003, 16'h001F, 16'h0000};
  logic [15:0] hi_tab [6] = '{16'h0042, 16'h0106, 16'h0011, 16'h0005, 16'h0021, 16'h0000};

  timer_core timer_core_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbc_tick(tbc_tick), .external_clock_pin(ext_clk), .capture_input_pin(cap_a),
    .enhanced_capture_input_b(cap_b), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .irq(irq)
  );
  timer_pins_model timer_pins_model_i (
    .clk(clk), .tbc_tick(tbc_tick), .external_clock_pin(ext_clk),
    .capture_input_pin(cap_a), .enhanced_capture_input_b(cap_b)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // APB master tasks
  // ----------------------------------------
  // One transfer: setup, then access held until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // High byte first, then the buffered low byte.
  task automatic rd16(input logic [7:0] hi, input logic [7:0] lo, output logic [15:0] v);
    xfer(1'b0, hi, 32'h0);
    v[15:8] = q[7:0];
    xfer(1'b0, lo, 32'h0);
    v[7:0] = q[7:0];
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) errors++;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 40; a += 4) rd_chk(a[7:0], 32'h0);
    rd_chk(8'h2C, 32'h0);
    `CHK(err, 1'b1)
    `CHK({irq, timer_out_en}, 2'h0)
    $display("test reset done");
    wr(cmp_a_low_addr, 32'hAB);
    wr(cmp_a_high_addr, 32'h3);
    rd_chk(cmp_a_high_addr, 32'h3);
    rd_chk(cmp_a_low_addr, 32'hAB);
    wr(cmp_a_low_addr, 32'h55);
    rd_chk(cmp_a_high_addr, 32'h3);
    rd_chk(cmp_a_low_addr, 32'hAB);
    wr(cmp_b_low_addr, 32'hFF);
    wr(cmp_b_high_addr, 32'hFF);
    rd_chk(cmp_b_high_addr, 32'h3);
    rd_chk(cmp_a_high_addr, 32'h3);
    rd_chk(cmp_b_low_addr, 32'hAB);
    $display("test buffers done");
    for (int i = 0; i < 6; i++) begin
      wr(ctrl_zero_addr, 32'h0);
      wr(ctrl_zero_addr, {24'h0, 1'b0, i[2:0], 4'h8});
      repeat (256) @(posedge clk);
      rd16(count_high_addr, count_low_addr, cnt);
      `CHK(cnt >= lo_tab[i] && cnt <= hi_tab[i], 1'b1)
    end
    $display("test clock sources done");
    wr(cmp_a_low_addr, 32'h28);
    wr(cmp_a_high_addr, 32'h0);
    wr(mask_addr, 32'h7);
    wr(ctrl_two_addr, 32'h1);
    for (int act = 1; act < 4; act++) begin
      wr(ctrl_zero_addr, 32'h0);
      wr(status_addr, 32'h7);
      wr(ctrl_one_addr, {24'h0, 2'h0, act[1:0], act == 1, 2'h0, 1'b1});
      wr(ctrl_zero_addr, 32'h18);
      wait_irq();
      wr(ctrl_zero_addr, 32'h98);
      idle(20);
      `CHK(timer_out, act != 1)
      rd_chk(status_addr, 32'h1);
      wr(mask_addr, 32'h0);
      idle(2);
      `CHK(irq, 1'b0)
      wr(mask_addr, 32'h7);
      idle(2);
      `CHK(irq, 1'b1)
      wr(status_addr, 32'h1);
      idle(2);
      `CHK(irq, 1'b0)
    end
    `CHK(timer_out_en, 1'b1)
    $display("test compare done");
    wr(cmp_b_low_addr, 32'h14);
    wr(cmp_b_high_addr, 32'h0);
    wr(ctrl_one_addr, 32'h0);
    wr(ctrl_zero_addr, 32'h0);
    wr(status_addr, 32'h7);
    wr(ctrl_zero_addr, 32'h19);
    idle(200);
    rd_chk(status_addr, 32'h7);
    rd16(count_high_addr, count_low_addr, cnt);
    `CHK(cnt < 16'h0081, 1'b1)
    $display("test period done");
    for (int e = 0; e < 2; e++) begin
      wr(ctrl_zero_addr, 32'h0);
      wr(ctrl_zero_addr, e == 0 ? 32'h68 : 32'h78);
      timer_pins_model_i.clock_pulses(7);
      idle(6);
      rd16(count_high_addr, count_low_addr, cnt);
      `CHK(cnt, 16'h0007)
    end
    $display("test event count done");
    wr(ctrl_zero_addr, 32'h0);
    wr(ctrl_zero_addr, 32'h58);
    for (int io = 0; io < 3; io++) begin
      wr(ctrl_one_addr, {24'h0, 2'h1, io[1:0], 4'h0});
      wr(ctrl_two_addr, {26'h0, io[1:0], 4'h1});
      wr(status_addr, 32'h7);
      timer_pins_model_i.capture_level(1'b1);
      rd_chk(status_addr, io == 1 ? 32'h0 : 32'h5);
      wr(status_addr, 32'h7);
      timer_pins_model_i.capture_level(1'b0);
      rd_chk(status_addr, io == 0 ? 32'h0 : 32'h5);
    end
    $display("test capture done");
    wr(cmp_a_low_addr, 32'h28);
    wr(cmp_a_high_addr, 32'h0);
    wr(ctrl_zero_addr, 32'h10);
    wr(ctrl_one_addr, 32'h0);
    wr(ctrl_two_addr, 32'h3);
    timer_pins_model_i.clock_pulses(1);
    idle(8);
    `CHK(timer_out, 1'b1)
    idle(60);
    `CHK(timer_out, 1'b0)
    rd_chk(ctrl_zero_addr, 32'h10);
    $display("test single pulse done");
    wr(ctrl_zero_addr, 32'h58);
    wr(ctrl_one_addr, 32'h80);
    idle(1);
    `CHK(timer_out, 1'b1)
    wr(ctrl_one_addr, 32'h84);
    idle(1);
    `CHK(timer_out, 1'b0)
    $display("test pwm done");
    end_sim();
  end
endmodule

// File: verification/timer_pins_model.sv
// Far-side model of the timer pins: clock pin, capture pins, time-base tick.
// Assumes the bench calls its tasks from a process that follows clk.
`timescale 1ns/1ps

module timer_pins_model (
  input wire logic clk,
  output logic tbc_tick,
  output logic external_clock_pin,
  output logic capture_input_pin,
  output logic enhanced_capture_input_b
);
  logic [2:0] tbc_count;

  // Idle levels at time zero, so no edge is seen before a test asks.
  initial begin
    tbc_count = 3'h0;
    tbc_tick = 1'b0;
    external_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    enhanced_capture_input_b = 1'b0;
  end

  // Time-base tick: one clk pulse in every eight.
  always @(posedge clk) begin
    tbc_count <= tbc_count + 3'h1;
    tbc_tick <= (tbc_count == 3'h7);
  end

  // Pulses on the clock pin, high held four cycles and low at least four, for the synchroniser.
  task automatic clock_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      external_clock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      external_clock_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // Moves both capture pins to a level and holds it six cycles.
  task automatic capture_level(input logic lvl);
    @(posedge clk);
    capture_input_pin <= lvl;
    enhanced_capture_input_b <= lvl;
    repeat (6) @(posedge clk);
  endtask
endmodule
